// ### fault_history_recall_ui_test.sv
// self-checking bench for the fault history recall block
`timescale 1ns/1ps
module fault_history_recall_ui_test;
  import fhr_pkg::*;
  localparam int unsigned TK = 10;
  localparam fhr_seg_t HEX [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d,
    7'h7d, 7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  typedef struct { int hold; fhr_seg_t t; fhr_seg_t o; } fhr_row_t;
  fhr_row_t rows [4] = '{'{100, 7'h00, 7'h00}, '{700, 7'h00, 7'h00},
    '{1600, 7'h00, 7'h00}, '{300, 7'h66, 7'h6d}};
  fhr_code_t hist [7] = '{8'h01, 8'h21, 8'h33, 8'h33, 8'h33, 8'h33, 8'h45};
  fhr_code_t older [4] = '{8'h33, 8'h33, 8'h33, 8'h21};
  fhr_code_t live [2] = '{8'h7e, 8'hc3};
  logic clk;
  logic rstn;
  logic recallBtnN;
  logic netBtnN;
  logic demandPin;
  logic faultValid;
  fhr_code_t faultCode;
  logic faultActive;
  fhr_code_t activeCode;
  logic commFail;
  logic netRx;
  fhr_seg_t segTens;
  fhr_seg_t segOnes;
  logic ledRed;
  logic ledGreen;
  logic netPowerUpReset;
  logic netFactoryReset;
  logic redQ;
  int fails;
  int checksDone;
  int puCount;
  int frCount;
  int redRises;
  int r0;
  int p0;
  int f0;

  fhr_recall #(.TICK_CYCLES(TK)) dut_u (
    .clk(clk), .rstn(rstn), .recallBtnN(recallBtnN), .netBtnN(netBtnN),
    .demandPin(demandPin), .faultValid(faultValid), .faultCode(faultCode),
    .faultActive(faultActive), .activeCode(activeCode), .commFail(commFail),
    .netRx(netRx), .segTens(segTens), .segOnes(segOnes), .ledRed(ledRed),
    .ledGreen(ledGreen), .netPowerUpReset(netPowerUpReset),
    .netFactoryReset(netFactoryReset));
  fhr_panel panel_u (.clk(clk), .recallBtnN(recallBtnN), .netBtnN(netBtnN));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // counted on the falling edge, away from the sampling edge
  always @(negedge clk) begin
    redQ <= ledRed;
    if (ledRed === 1'b1 && redQ === 1'b0) redRises++;
    if (netPowerUpReset === 1'b1) puCount++;
    if (netFactoryReset === 1'b1) frCount++;
  end

  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : reportAndStop
  task automatic cmpSeg(input fhr_seg_t t, input fhr_seg_t o);
    checksDone++;
    if (segTens !== t || segOnes !== o) begin
      fails++;
      $display("unexpected at %0t: got %h %h want %h %h", $time, segTens,
        segOnes, t, o);
    end
  endtask : cmpSeg
  task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmpVal
  task automatic cmpCode(input fhr_code_t c);
    cmpSeg(HEX[c[7:4]], HEX[c[3:0]]);
  endtask : cmpCode
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk);
  endtask : ticks
  task automatic hold(input int n);
    fhr_seg_t s0;
    panel_u.push(1'b0);
    ticks(n);
    s0 = segTens;
    if (n >= 250 && n < 500 && !demandPin) cmpSeg(7'h40, 7'h40);
    // blink toggles every 50 ticks: samples 50 ticks apart differ
    if (n >= 1050 && n < 1450) begin
      ticks(50);
      cmpVal(s0 ^ segTens, 32'h40);
    end
    panel_u.lift(1'b0);
    ticks(5);
  endtask : hold
  task automatic record(input fhr_code_t c);
    faultCode <= c;
    faultValid <= 1'b1;
    @(posedge clk);
    faultValid <= 1'b0;
    @(posedge clk);
  endtask : record

  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    reportAndStop();
  end

  initial begin
    rstn = 1'b0;
    demandPin = 1'b0;
    faultValid = 1'b0;
    faultCode = 8'h00;
    faultActive = 1'b0;
    activeCode = 8'h00;
    commFail = 1'b0;
    netRx = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    r0 = redRises;
    ticks(190);
    cmpVal(redRises - r0, 2);
    netRx <= 1'b1;
    @(posedge clk);
    netRx <= 1'b0;
    repeat (4) @(posedge clk);
    cmpVal(ledGreen, 1);
    ticks(15);
    cmpVal(ledGreen, 0);
    foreach (hist[i]) record(hist[i]);
    foreach (rows[i]) begin
      hold(rows[i].hold);
      cmpSeg(rows[i].t, rows[i].o);
    end
    foreach (older[i]) begin
      hold(30);
      cmpCode(older[i]);
    end
    hold(30);
    r0 = segTens;
    ticks(50);
    cmpVal(r0 ^ segTens, 32'h40);
    ticks(200);
    cmpSeg(7'h00, 7'h00);
    demandPin <= 1'b1;
    ticks(2);
    hold(300);
    cmpSeg(7'h00, 7'h00);
    demandPin <= 1'b0;
    faultActive <= 1'b1;
    foreach (live[i]) begin
      activeCode <= live[i];
      ticks(2);
      cmpCode(live[i]);
    end
    faultActive <= 1'b0;
    ticks(2);
    hold(1200);
    cmpCode(8'h88);
    ticks(250);
    record(8'h5a);
    hold(300);
    cmpCode(8'h5a);
    hold(30);
    ticks(250);
    cmpSeg(7'h00, 7'h00);
    p0 = puCount;
    f0 = frCount;
    panel_u.push(1'b1);
    ticks(520);
    panel_u.lift(1'b1);
    ticks(5);
    cmpVal(frCount - f0, 1);
    cmpVal(puCount - p0, 0);
    panel_u.push(1'b1);
    ticks(20);
    panel_u.lift(1'b1);
    ticks(5);
    cmpVal(puCount - p0, 1);
    commFail <= 1'b1;
    ticks(620);
    r0 = redRises;
    ticks(200);
    cmpVal(redRises - r0, 1);
    reportAndStop();
  end
endmodule : fault_history_recall_ui_test

// ### fhr_button.sv
// push-button synchroniser, debouncer and hold timer
`timescale 1ns/1ps
`include "fhr_defines.svh"

module fhr_button (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              tick,
  input  wire logic              btnN,
  output logic                   pressed,
  output logic                   pressEdge,
  output logic                   releaseEdge,
  output fhr_pkg::fhr_hold_t     holdTicks
);
  import fhr_pkg::*;

  localparam logic [3:0] DEB_TICKS = 4'(`FHR_TICKS_UP(`FHR_DEB_MS));

  logic       syncA;
  logic       syncB;
  logic [3:0] debCnt;

  wire raw        = ~syncB;
  wire differ     = raw != pressed;
  wire flip       = differ && tick && (debCnt == DEB_TICKS - 4'h1);
  wire holdSat    = &holdTicks;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      syncA <= 1'b1;
      syncB <= 1'b1;
    end else begin
      syncA <= btnN;
      syncB <= syncA;
    end
  end

  // stable for the debounce time before the level flips
  always_ff @(posedge clk) begin
    if (!rstn || !differ || flip)
      debCnt <= 4'h0;
    else if (tick)
      debCnt <= debCnt + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pressed     <= 1'b0;
      pressEdge   <= 1'b0;
      releaseEdge <= 1'b0;
    end else begin
      pressed     <= flip ? raw : pressed;
      pressEdge   <= flip && raw;
      releaseEdge <= flip && !raw;
    end
  end

  // hold time in ticks, saturating
  always_ff @(posedge clk) begin
    if (!rstn || !pressed)
      holdTicks <= '0;
    else if (tick && !holdSat)
      holdTicks <= holdTicks + 12'h001;
  end

endmodule : fhr_button

// ### fhr_defines.svh
// timing and encoding constants for the fault history recall block
`ifndef FHR_DEFINES_SVH
`define FHR_DEFINES_SVH

`define FHR_CLK_HZ        10000000
`define FHR_TICK_MS       10
`define FHR_TICK_CYCLES   (`FHR_CLK_HZ / 1000 * `FHR_TICK_MS)

// least times round up, longest times round down
`define FHR_TICKS_UP(ms)  (((ms) + `FHR_TICK_MS - 1) / `FHR_TICK_MS)
`define FHR_TICKS_DN(ms)  ((ms) / `FHR_TICK_MS)

`define FHR_SHOW_MIN_MS   2000
`define FHR_SHOW_MAX_MS   5000
`define FHR_CLR_MIN_MS    10000
`define FHR_CLR_MAX_MS    15000
`define FHR_NET_HOLD_MS   5000
`define FHR_DEB_MS        20
`define FHR_BLINK_MS      500
`define FHR_END_MS        2000
`define FHR_RX_MS         100
`define FHR_FLASH_ON_MS   250
`define FHR_FLASH_SLOT_MS 500
`define FHR_FLASH_SLOTS   4
`define FHR_DEFAULT_REPS  3

`define FHR_HIST_DEPTH    6
`define FHR_REPEAT_MAX    3
`define FHR_HOLD_W        12

`define FHR_SYM_DASH      5'h10
`define FHR_SYM_BLANK     5'h11
`define FHR_SYM_EIGHT     5'h08
`define FHR_SEG_DASH      7'h40
`define FHR_SEG_BLANK     7'h00

`endif

// ### fhr_panel.sv
// service panel: two push-buttons with pull-ups and contact chatter
`timescale 1ns/1ps
module fhr_panel (
  input  wire logic clk,
  output logic      recallBtnN,
  output logic      netBtnN
);
  initial begin
    recallBtnN = 1'b1;
    netBtnN = 1'b1;
  end
  // chatter for some cycles before the contact settles low
  task automatic push(input bit net);
    for (int i = 0; i < 7; i++) begin
      if (net) netBtnN <= i[0];
      else recallBtnN <= i[0];
      repeat (3) @(posedge clk);
    end
  endtask : push
  // pull-up takes the pin high once let go
  task automatic lift(input bit net);
    if (net) netBtnN <= 1'b1;
    else recallBtnN <= 1'b1;
    @(posedge clk);
  endtask : lift
endmodule : fhr_panel

// ### fhr_pkg.sv
// types shared by the fault history recall block
package fhr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HOLD  = 3'b001,
    ST_ABORT = 3'b010,
    ST_SHOW  = 3'b011,
    ST_STEP  = 3'b100,
    ST_END   = 3'b101,
    ST_CLEAR = 3'b110
  } fhr_state_t;

  typedef logic [7:0] fhr_code_t;
  typedef logic [4:0] fhr_sym_t;
  typedef logic [6:0] fhr_seg_t;
  typedef logic [11:0] fhr_hold_t;

endpackage : fhr_pkg

// ### fhr_recall.sv
// fault history recall, seven-segment display and network indicators
`timescale 1ns/1ps
`include "fhr_defines.svh"

// Behaviour
// - keep last six fault codes for recall
// - recall or clear only in idle, no demand
// - hold 2 to 5 s shows double dash
// - release in 2-5 s shows newest code
// - each press steps to next older code
// - after last code blink dash, then idle
// - hold 10 to 15 s blinks double dash
// - release in 10-15 s shows 88, clears
// - release before 2 s returns to idle
// - release in 5-10 s returns to idle
// - hold beyond 15 s abandons, keeps history
// - consecutive repeats shown at most three times
// - active fault code shown on display in idle
// - network button held over 5 s resets
// - red LED flashes network status patterns
// - green LED follows receive traffic
// - short press power-up, 5 s factory reset
// - red one flash fail, two flashes default
module fhr_recall #(
  parameter int unsigned TICK_CYCLES = `FHR_TICK_CYCLES
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            recallBtnN,
  input  wire logic            netBtnN,
  input  wire logic            demandPin,
  input  wire logic            faultValid,
  input  wire fhr_pkg::fhr_code_t faultCode,
  input  wire logic            faultActive,
  input  wire fhr_pkg::fhr_code_t activeCode,
  input  wire logic            commFail,
  input  wire logic            netRx,
  output fhr_pkg::fhr_seg_t    segTens,
  output fhr_pkg::fhr_seg_t    segOnes,
  output logic                 ledRed,
  output logic                 ledGreen,
  output logic                 netPowerUpReset,
  output logic                 netFactoryReset
);
  import fhr_pkg::*;

  localparam fhr_hold_t T_SHOW_MIN = 12'(`FHR_TICKS_UP(`FHR_SHOW_MIN_MS));
  localparam fhr_hold_t T_SHOW_MAX = 12'(`FHR_TICKS_DN(`FHR_SHOW_MAX_MS));
  localparam fhr_hold_t T_CLR_MIN  = 12'(`FHR_TICKS_UP(`FHR_CLR_MIN_MS));
  localparam fhr_hold_t T_CLR_MAX  = 12'(`FHR_TICKS_DN(`FHR_CLR_MAX_MS));
  localparam fhr_hold_t T_NET      = 12'(`FHR_TICKS_DN(`FHR_NET_HOLD_MS));
  localparam logic [7:0] T_BLINK   = 8'(`FHR_TICKS_DN(`FHR_BLINK_MS));
  localparam logic [7:0] T_END     = 8'(`FHR_TICKS_DN(`FHR_END_MS));
  localparam logic [3:0] T_RX      = 4'(`FHR_TICKS_UP(`FHR_RX_MS));
  localparam logic [5:0] T_ON      = 6'(`FHR_TICKS_DN(`FHR_FLASH_ON_MS));
  localparam logic [5:0] T_SLOT    = 6'(`FHR_TICKS_DN(`FHR_FLASH_SLOT_MS));
  localparam logic [1:0] N_SLOTS   = 2'(`FHR_FLASH_SLOTS - 1);
  localparam logic [1:0] N_REPS    = 2'(`FHR_DEFAULT_REPS);
  localparam logic [2:0] DEPTH     = 3'(`FHR_HIST_DEPTH);
  localparam logic [1:0] REP_MAX   = 2'(`FHR_REPEAT_MAX);

  function automatic fhr_seg_t segOf(input fhr_sym_t sym);
    fhr_seg_t seg;
    seg = `FHR_SEG_BLANK;
    unique case (sym)
      5'h00: seg = 7'h3f;
      5'h01: seg = 7'h06;
      5'h02: seg = 7'h5b;
      5'h03: seg = 7'h4f;
      5'h04: seg = 7'h66;
      5'h05: seg = 7'h6d;
      5'h06: seg = 7'h7d;
      5'h07: seg = 7'h07;
      5'h08: seg = 7'h7f;
      5'h09: seg = 7'h6f;
      5'h0a: seg = 7'h77;
      5'h0b: seg = 7'h7c;
      5'h0c: seg = 7'h39;
      5'h0d: seg = 7'h5e;
      5'h0e: seg = 7'h79;
      5'h0f: seg = 7'h71;
      `FHR_SYM_DASH: seg = `FHR_SEG_DASH;
      default: seg = `FHR_SEG_BLANK;
    endcase
    return seg;
  endfunction : segOf

  // ---- tick, input sync ----
  logic [16:0] tickCnt;
  logic        tick;
  logic        demandA;
  logic        demandB;

  wire tickWrap = tickCnt == 17'(TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!rstn || tickWrap)
      tickCnt <= 17'h00000;
    else
      tickCnt <= tickCnt + 17'h00001;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick    <= 1'b0;
      demandA <= 1'b0;
      demandB <= 1'b0;
    end else begin
      tick    <= tickWrap;
      demandA <= demandPin;
      demandB <= demandA;
    end
  end

  // ---- buttons ----
  logic      recPressed;
  logic      recPress;
  logic      recRelease;
  fhr_hold_t recHold;
  logic      netPressed;
  logic      netRelease;
  fhr_hold_t netHold;

  fhr_button u_recall_btn (
    .clk         (clk),
    .rstn        (rstn),
    .tick        (tick),
    .btnN        (recallBtnN),
    .pressed     (recPressed),
    .pressEdge   (recPress),
    .releaseEdge (recRelease),
    .holdTicks   (recHold)
  );

  fhr_button u_net_btn (
    .clk         (clk),
    .rstn        (rstn),
    .tick        (tick),
    .btnN        (netBtnN),
    .pressed     (netPressed),
    .pressEdge   (),
    .releaseEdge (netRelease),
    .holdTicks   (netHold)
  );

  // ---- blink and state timers ----
  logic [7:0] blinkCnt;
  logic       blinkOn;
  logic [7:0] stateTicks;
  fhr_state_t state;
  fhr_state_t next_state;

  wire blinkWrap = tick && (blinkCnt == T_BLINK - 8'h01);
  wire endWrap   = tick && (stateTicks == T_END - 8'h01);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      blinkCnt <= 8'h00;
      blinkOn  <= 1'b1;
    end else if (blinkWrap) begin
      blinkCnt <= 8'h00;
      blinkOn  <= ~blinkOn;
    end else if (tick) begin
      blinkCnt <= blinkCnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || next_state != state)
      stateTicks <= 8'h00;
    else if (tick)
      stateTicks <= stateTicks + 8'h01;
  end

  // ---- history ----
  fhr_code_t  hist [`FHR_HIST_DEPTH];
  logic [2:0] histCnt;
  logic [2:0] idx;
  logic [1:0] runLen;
  fhr_code_t  shown;

  wire inShow  = recHold >= T_SHOW_MIN && recHold < T_SHOW_MAX;
  wire inClr   = recHold >= T_CLR_MIN && recHold < T_CLR_MAX;
  wire overMax = recHold >= T_CLR_MAX;
  wire clearNow = state == ST_HOLD && recRelease && inClr;

  wire fhr_code_t curEntry = (idx < DEPTH) ? hist[idx] : 8'h00;
  wire stepDone = idx >= histCnt;
  wire sameCode = curEntry == shown;
  wire stepSkip = !stepDone && sameCode && runLen == REP_MAX;
  wire showNext = state == ST_STEP && !stepDone && !stepSkip;

  // new fault shifts in; a fault in the clear cycle survives
  always_ff @(posedge clk) begin
    if (!rstn)
      hist[0] <= 8'h00;
    else if (faultValid)
      hist[0] <= faultCode;
  end

  genvar gi;
  generate
    for (gi = 1; gi < `FHR_HIST_DEPTH; gi++) begin : g_hist
      always_ff @(posedge clk) begin
        if (!rstn)
          hist[gi] <= 8'h00;
        else if (faultValid)
          hist[gi] <= hist[gi-1];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn)
      histCnt <= 3'h0;
    else if (faultValid && clearNow)
      histCnt <= 3'h1;
    else if (clearNow)
      histCnt <= 3'h0;
    else if (faultValid && histCnt != DEPTH)
      histCnt <= histCnt + 3'h1;
  end

  // ---- recall sequencer ----
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (recPress && !demandB)
          next_state = ST_HOLD;
      ST_HOLD:
        if (recRelease) begin
          if (inShow)
            next_state = (histCnt == 3'h0) ? ST_END : ST_SHOW;
          else if (inClr)
            next_state = ST_CLEAR;
          else
            next_state = ST_IDLE;
        end else if (overMax) begin
          next_state = ST_ABORT;
        end
      ST_ABORT:
        if (!recPressed)
          next_state = ST_IDLE;
      ST_SHOW:
        if (recPress)
          next_state = ST_STEP;
      ST_STEP:
        if (stepDone)
          next_state = ST_END;
        else if (!stepSkip)
          next_state = ST_SHOW;
      ST_END:
        if (endWrap)
          next_state = ST_IDLE;
      ST_CLEAR:
        if (endWrap)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  wire enterFirst = state == ST_HOLD && next_state == ST_SHOW;
  wire advance = (state == ST_SHOW && recPress) ||
                 (state == ST_STEP && stepSkip);

  always_ff @(posedge clk) begin
    if (!rstn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk) begin
    if (!rstn || state == ST_IDLE || state == ST_HOLD)
      idx <= 3'h0;
    else if (advance)
      idx <= idx + 3'h1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      shown  <= 8'h00;
      runLen <= 2'h0;
    end else if (enterFirst) begin
      shown  <= hist[0];
      runLen <= 2'h1;
    end else if (showNext) begin
      shown  <= curEntry;
      runLen <= sameCode ? runLen + 2'h1 : 2'h1;
    end
  end

  // ---- display ----
  fhr_sym_t next_tens;
  fhr_sym_t next_ones;

  always_comb begin
    next_tens = `FHR_SYM_BLANK;
    next_ones = `FHR_SYM_BLANK;
    unique case (state)
      ST_IDLE:
        if (faultActive) begin
          next_tens = {1'b0, activeCode[7:4]};
          next_ones = {1'b0, activeCode[3:0]};
        end
      ST_HOLD:
        if (inShow || (inClr && blinkOn)) begin
          next_tens = `FHR_SYM_DASH;
          next_ones = `FHR_SYM_DASH;
        end
      ST_SHOW, ST_STEP: begin
        next_tens = {1'b0, shown[7:4]};
        next_ones = {1'b0, shown[3:0]};
      end
      ST_END:
        if (blinkOn) begin
          next_tens = `FHR_SYM_DASH;
          next_ones = `FHR_SYM_DASH;
        end
      ST_CLEAR: begin
        next_tens = `FHR_SYM_EIGHT;
        next_ones = `FHR_SYM_EIGHT;
      end
      default: begin
        next_tens = `FHR_SYM_BLANK;
        next_ones = `FHR_SYM_BLANK;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      segTens <= `FHR_SEG_BLANK;
      segOnes <= `FHR_SEG_BLANK;
    end else begin
      segTens <= segOf(next_tens);
      segOnes <= segOf(next_ones);
    end
  end

  // ---- network button ----
  logic factoryFired;

  wire factoryHit = netPressed && !factoryFired && netHold > T_NET;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      factoryFired    <= 1'b0;
      netPowerUpReset <= 1'b0;
      netFactoryReset <= 1'b0;
    end else begin
      factoryFired    <= netPressed && (factoryFired || factoryHit);
      netPowerUpReset <= netRelease && !factoryFired;
      netFactoryReset <= factoryHit;
    end
  end

  // ---- red status LED ----
  logic [5:0] flashSub;
  logic [1:0] flashSlot;
  logic [1:0] defaultReps;

  wire subWrap    = tick && flashSub == T_SLOT - 6'h01;
  wire periodWrap = subWrap && flashSlot == N_SLOTS;
  wire [2:0] flashN = (defaultReps != 2'h0) ? 3'h2 :
                      commFail ? 3'h1 : 3'h0;

  always_ff @(posedge clk) begin
    if (!rstn || factoryHit) begin
      flashSub  <= 6'h00;
      flashSlot <= 2'h0;
    end else if (subWrap) begin
      flashSub  <= 6'h00;
      flashSlot <= flashSlot + 2'h1;
    end else if (tick) begin
      flashSub  <= flashSub + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || factoryHit)
      defaultReps <= N_REPS;
    else if (periodWrap && defaultReps != 2'h0)
      defaultReps <= defaultReps - 2'h1;
  end

  // ---- LEDs ----
  logic [3:0] rxStretch;

  always_ff @(posedge clk) begin
    if (!rstn)
      rxStretch <= 4'h0;
    else if (netRx)
      rxStretch <= T_RX;
    else if (tick && rxStretch != 4'h0)
      rxStretch <= rxStretch - 4'h1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ledRed   <= 1'b0;
      ledGreen <= 1'b0;
    end else begin
      ledRed   <= ({1'b0, flashSlot} < flashN) && flashSub < T_ON;
      ledGreen <= rxStretch != 4'h0;
    end
  end

endmodule : fhr_recall

// ### fhr_recall_monitor.sv
// concurrent checks on the fault history recall ports
`timescale 1ns/1ps
`include "fhr_defines.svh"
module fhr_recall_monitor #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic               recallBtnN,
  input wire logic               netBtnN,
  input wire logic               demandPin,
  input wire logic               faultValid,
  input wire fhr_pkg::fhr_code_t faultCode,
  input wire logic               faultActive,
  input wire fhr_pkg::fhr_code_t activeCode,
  input wire logic               commFail,
  input wire logic               netRx,
  input wire fhr_pkg::fhr_seg_t  segTens,
  input wire fhr_pkg::fhr_seg_t  segOnes,
  input wire logic               ledRed,
  input wire logic               ledGreen,
  input wire logic               netPowerUpReset,
  input wire logic               netFactoryReset
);
  import fhr_pkg::*;
  int unsigned sinceRx;
  int unsigned redOn;
  int unsigned netLow;
  always_ff @(posedge clk) begin
    if (!rstn || netRx) sinceRx <= 32'h0;
    else sinceRx <= sinceRx + 32'h1;
  end
  always_ff @(posedge clk) begin
    if (!rstn || !ledRed) redOn <= 32'h0;
    else redOn <= redOn + 32'h1;
  end
  always_ff @(posedge clk) begin
    if (!rstn || netBtnN) netLow <= 32'h0;
    else netLow <= netLow + 32'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence greenLit;
    ##[1:2] ledGreen;
  endsequence
  chk_reset_quiet: assert property ($rose(rstn) |-> segTens == 7'h00
    && segOnes == 7'h00 && !ledRed && !ledGreen)
    else $error("outputs not quiet after reset");
  chk_green_rx: assert property (netRx |-> greenLit)
    else $error("green led not lit after receive");
  chk_green_stretch: assert property (ledGreen |-> sinceRx <= 12 * TICK_CYCLES)
    else $error("green led lit too long");
  chk_red_flash: assert property (redOn <= 26 * TICK_CYCLES)
    else $error("red led flash too long");
  chk_dash_pair: assert property (segTens == `FHR_SEG_DASH
    |-> segOnes == `FHR_SEG_DASH)
    else $error("dash shown on one digit only");
  chk_factory_hold: assert property (netFactoryReset
    |-> netLow >= 500 * TICK_CYCLES)
    else $error("factory reset before full hold");
  chk_factory_once: assert property (netFactoryReset |=> !netFactoryReset)
    else $error("factory reset pulse too long");
  chk_powerup_once: assert property (netPowerUpReset |=> !netPowerUpReset)
    else $error("power-up reset pulse too long");
  chk_powerup_free: assert property (netPowerUpReset
    |-> netBtnN && !netFactoryReset)
    else $error("power-up reset while button held");
endmodule : fhr_recall_monitor

bind fhr_recall fhr_recall_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (
  .clk(clk), .rstn(rstn), .recallBtnN(recallBtnN), .netBtnN(netBtnN),
  .demandPin(demandPin), .faultValid(faultValid), .faultCode(faultCode),
  .faultActive(faultActive), .activeCode(activeCode), .commFail(commFail),
  .netRx(netRx), .segTens(segTens), .segOnes(segOnes), .ledRed(ledRed),
  .ledGreen(ledGreen), .netPowerUpReset(netPowerUpReset),
  .netFactoryReset(netFactoryReset));
